// File: hw/rcc_calendar.sv
// calendar date, month and year counters with month length and leap years
`timescale 1ns/1ps
`default_nettype none
module rcc_calendar (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // day carry from the hour counter
    input wire logic day_tick_in,
    // software load
    input wire logic load_in,
    input wire logic [1:0] load_sel_in,
    input wire logic [7:0] load_data_in,
    // state
    output rcc_pkg::rcc_cal_date_t date_out,
    output logic year_tick_out
);
    function automatic logic [7:0] last_day(input logic [7:0] month, input logic [7:0] year);
        logic leap;
        leap = (year >= rcc_pkg::LEAP_MIN) && (year <= rcc_pkg::LEAP_MAX)
            && (year[1:0] == 2'h0);
        case (month)
            8'h04, 8'h06, 8'h09, 8'h0B: last_day = rcc_pkg::DAYS_30;
            rcc_pkg::MONTH_FEB: last_day = leap ? rcc_pkg::DAYS_29 : rcc_pkg::DAYS_28;
            default: last_day = rcc_pkg::DAYS_31;
        endcase
    endfunction

    logic [7:0] date_q;
    logic [7:0] month_q;
    logic [7:0] year_q;
    logic year_tick_q;
    logic date_wrap;
    logic month_wrap;

    assign date_wrap = date_q >= last_day(month_q, year_q);
    assign month_wrap = month_q >= rcc_pkg::MONTH_LAST;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            date_q <= rcc_pkg::DATE_RESET;
            month_q <= rcc_pkg::MONTH_RESET;
            year_q <= rcc_pkg::YEAR_RESET;
            year_tick_q <= 1'b0;
        end
        else
        begin
            year_tick_q <= 1'b0;
            if (load_in)
            begin
                case (load_sel_in)
                    2'h0: date_q <= load_data_in;
                    2'h1: month_q <= load_data_in;
                    default: year_q <= load_data_in;
                endcase
            end
            else if (day_tick_in)
            begin
                if (date_wrap)
                begin
                    date_q <= rcc_pkg::DATE_RESET;
                    if (month_wrap)
                    begin
                        month_q <= rcc_pkg::MONTH_FIRST;
                        year_q <= year_q + 8'h01;
                        year_tick_q <= 1'b1;
                    end
                    else
                        month_q <= month_q + 8'h01;
                end
                else
                    date_q <= date_q + 8'h01;
            end
        end
    end

    assign date_out = '{date: date_q, month: month_q, year: year_q};
    assign year_tick_out = year_tick_q;
endmodule // rcc_calendar
`default_nettype wire

// File: hw/rcc_pulse_gen.sv
// calibration pulse generator: square wave from the selected half period (the 500 Hz setting uses the same half period as 512 Hz)
`timescale 1ns/1ps
`default_nettype none
module rcc_pulse_gen (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // control
    input wire logic enable_in,
    input wire rcc_pkg::rcc_freq_sel_t freq_sel_in,
    // output wave
    output logic wave_out
);
    typedef enum logic [1:0] {
        PG_IDLE = 2'h0,
        PG_HIGH = 2'h1,
        PG_LOW = 2'h3
    } rcc_pg_state_t;

    rcc_pg_state_t state_q;
    logic [15:0] count_q;
    logic [15:0] half;
    rcc_pkg::rcc_freq_sel_t freq_q;

    always_comb
    begin
        case (freq_sel_in)
            rcc_pkg::FREQ_1HZ: half = rcc_pkg::HALF_1HZ;
            rcc_pkg::FREQ_512HZ: half = rcc_pkg::HALF_512HZ;
            rcc_pkg::FREQ_500HZ: half = rcc_pkg::HALF_500HZ;
            default: half = rcc_pkg::HALF_16KHZ;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state_q <= PG_IDLE;
            count_q <= 16'h0000;
            freq_q <= rcc_pkg::FREQ_1HZ;
        end
        else
        begin
            freq_q <= freq_sel_in;
            case (state_q)
                PG_IDLE:
                begin
                    count_q <= 16'h0001;
                    if (enable_in)
                        state_q <= PG_HIGH;
                end
                PG_HIGH, PG_LOW:
                begin
                    // a frequency change restarts the wave so no runt half period is stretched
                    if (!enable_in || freq_q != freq_sel_in)
                        state_q <= PG_IDLE;
                    else if (count_q >= half)
                    begin
                        count_q <= 16'h0001;
                        state_q <= (state_q == PG_HIGH) ? PG_LOW : PG_HIGH;
                    end
                    else
                        count_q <= count_q + 16'h0001;
                end
                default: state_q <= PG_IDLE;
            endcase
        end
    end

    assign wave_out = (state_q == PG_HIGH);
endmodule // rcc_pulse_gen
`default_nettype wire

// File: hw/rcc_top.sv
// rtc calendar rollover and calibration pulse output with its registers
`timescale 1ns/1ps
`default_nettype none
module rcc_top (
    // clock and reset (calibrated 32.768 kHz timekeeping clock)
    input wire logic clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // power mode from the power manager (other clock domain)
    input wire logic deep_sleep_power_mode_in,
    // carry from the hour counter, same clock
    input wire logic day_tick_in,
    // timekeeping speed-up request to the sub-second counter
    output logic fast_timekeeping_out,
    // calendar
    output logic year_tick_out,
    // calibration pins
    output logic [3:0] cal_route_out,
    output logic [3:0] cal_route_oe_out
);
    rcc_pkg::rcc_cal_cfg_t cfg_q;
    logic [7:0] ctrl_q;
    logic [7:0] rdata_q;
    logic sleep_meta_q;
    logic sleep_sync_q;
    logic deep_sleep;
    logic wave;
    logic [3:0] route_en;
    logic [3:0] route_q;
    logic [3:0] route_oe_q;
    logic fast_q;
    logic year_tick_q;
    logic year_tick;
    logic cal_load;
    logic [1:0] cal_sel;
    rcc_pkg::rcc_cal_date_t date;

    function automatic logic is_short_window(input rcc_pkg::rcc_freq_sel_t f);
        is_short_window = (f == rcc_pkg::FREQ_500HZ) || (f == rcc_pkg::FREQ_16KHZ);
    endfunction

    // power mode synchroniser
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            sleep_meta_q <= 1'b0;
            sleep_sync_q <= 1'b0;
        end
        else
        begin
            sleep_meta_q <= deep_sleep_power_mode_in;
            sleep_sync_q <= sleep_meta_q;
        end
    end

    assign deep_sleep = sleep_sync_q | ctrl_q[rcc_pkg::BIT_DEEP_SLEEP];

    // configuration register
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            cfg_q <= rcc_pkg::rcc_cal_cfg_t'(rcc_pkg::CAL_CFG_RESET);
        else if (wr_in && addr_in == rcc_pkg::REG_CAL_CFG)
            cfg_q <= rcc_pkg::rcc_cal_cfg_t'(wdata_in);
    end

    // control register: software force of deep sleep for test
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            ctrl_q <= rcc_pkg::CTRL_RESET;
        else if (wr_in && addr_in == rcc_pkg::REG_CTRL)
            ctrl_q <= {7'h00, wdata_in[rcc_pkg::BIT_DEEP_SLEEP]};
    end

    // calendar writes go straight to the counters
    always_comb
    begin
        cal_load = 1'b0;
        cal_sel = 2'h0;
        if (wr_in)
        begin
            case (addr_in)
                rcc_pkg::REG_DATE:
                begin
                    cal_load = 1'b1;
                    cal_sel = 2'h0;
                end
                rcc_pkg::REG_MONTH:
                begin
                    cal_load = 1'b1;
                    cal_sel = 2'h1;
                end
                rcc_pkg::REG_YEAR:
                begin
                    cal_load = 1'b1;
                    cal_sel = 2'h2;
                end
                default:
                begin
                    cal_load = 1'b0;
                    cal_sel = 2'h0;
                end
            endcase
        end
    end

    rcc_calendar u_calendar (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .day_tick_in(day_tick_in),
        .load_in(cal_load),
        .load_sel_in(cal_sel),
        .load_data_in(wdata_in),
        .date_out(date),
        .year_tick_out(year_tick)
    );

    rcc_pulse_gen u_pulse (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .enable_in(cfg_q.cal_en),
        .freq_sel_in(cfg_q.cal_freq_select),
        .wave_out(wave)
    );

    // route gating per pin
    genvar gi;
    generate
        for (gi = 0; gi < rcc_pkg::ROUTES; gi++)
        begin : g_route
            if (gi == 0)
            begin : g_r0
                // in deep sleep route 0 needs the sleep route bit, not its own select
                assign route_en[gi] = cfg_q.cal_en
                    && (deep_sleep ? cfg_q.cal_out_sleep_route_enable
                    : cfg_q.route_sel[gi]);
            end
            else
            begin : g_rn
                assign route_en[gi] = cfg_q.cal_en && cfg_q.route_sel[gi]
                    && !deep_sleep;
            end
        end
    endgenerate

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            route_q <= 4'h0;
            route_oe_q <= 4'h0;
        end
        else
        begin
            route_q <= route_en & {rcc_pkg::ROUTES{wave}};
            route_oe_q <= route_en;
        end
    end

    // short window speeds timekeeping; only in the full power modes
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            fast_q <= 1'b0;
        else
            fast_q <= cfg_q.cal_en && is_short_window(cfg_q.cal_freq_select)
                && !deep_sleep;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            year_tick_q <= 1'b0;
        else
            year_tick_q <= year_tick;
    end

    // read data stands the cycle after the strobe only
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            rdata_q <= 8'h00;
        else if (rd_in)
        begin
            case (addr_in)
                rcc_pkg::REG_CAL_CFG: rdata_q <= cfg_q;
                rcc_pkg::REG_DATE: rdata_q <= date.date;
                rcc_pkg::REG_MONTH: rdata_q <= date.month;
                rcc_pkg::REG_YEAR: rdata_q <= date.year;
                rcc_pkg::REG_STATUS: rdata_q <= {5'h00, fast_q, wave, sleep_sync_q};
                rcc_pkg::REG_CTRL: rdata_q <= ctrl_q;
                default: rdata_q <= 8'h00;
            endcase
        end
        else
            rdata_q <= 8'h00;
    end

    assign rdata_out = rdata_q;
    assign cal_route_out = route_q;
    assign cal_route_oe_out = route_oe_q;
    assign fast_timekeeping_out = fast_q;
    assign year_tick_out = year_tick_q;
endmodule // rcc_top
`default_nettype wire

// File: shared/rcc_pkg.sv
// package for the rtc calendar and calibration output block
package rcc_pkg;
    // register map
    localparam logic [7:0] REG_CAL_CFG = 8'h0F;
    localparam logic [7:0] REG_DATE = 8'h06;
    localparam logic [7:0] REG_MONTH = 8'h07;
    localparam logic [7:0] REG_YEAR = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_CTRL = 8'h11;
    localparam logic [7:0] CAL_CFG_RESET = 8'h00;
    localparam logic [7:0] DATE_RESET = 8'h01;
    localparam logic [7:0] MONTH_RESET = 8'h01;
    localparam logic [7:0] YEAR_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // calibration config fields
    localparam int BIT_SLEEP_ROUTE = 7;
    localparam int BIT_CAL_EN = 6;
    localparam int FREQ_SEL_LSB = 4;
    localparam int ROUTES = 4;
    // control register fields
    localparam int BIT_DEEP_SLEEP = 0;
    // calendar constants
    localparam logic [7:0] MONTH_FIRST = 8'h01;
    localparam logic [7:0] MONTH_LAST = 8'h0C;
    localparam logic [7:0] MONTH_FEB = 8'h02;
    localparam logic [7:0] DAYS_31 = 8'h1F;
    localparam logic [7:0] DAYS_30 = 8'h1E;
    localparam logic [7:0] DAYS_29 = 8'h1D;
    localparam logic [7:0] DAYS_28 = 8'h1C;
    localparam logic [7:0] LEAP_MIN = 8'h04;
    localparam logic [7:0] LEAP_MAX = 8'h60;
    // timing: 32.768 kHz timekeeping clock feeds the block
    localparam int TK_HZ = 32768;
    localparam int FAST_FACTOR = 125;
    localparam int FAST_TK_HZ = TK_HZ * FAST_FACTOR;
    // half-periods in timekeeping ticks (the 500 Hz one worked out via fast mode ticks, then scaled back)
    localparam int HZ_1 = 1;
    localparam int HZ_512 = 512;
    localparam int HZ_500 = 500;
    localparam int HZ_16K = 16000;
    localparam logic [15:0] HALF_1HZ = 16'((TK_HZ / HZ_1) / 2);
    localparam logic [15:0] HALF_512HZ = 16'((TK_HZ / HZ_512) / 2);
    localparam logic [15:0] HALF_500HZ = 16'((FAST_TK_HZ / HZ_500) / 2 / FAST_FACTOR);
    localparam logic [15:0] HALF_16KHZ = 16'h0001;

    typedef enum logic [1:0] {
        FREQ_1HZ = 2'h0,
        FREQ_512HZ = 2'h1,
        FREQ_500HZ = 2'h2,
        FREQ_16KHZ = 2'h3
    } rcc_freq_sel_t;

    typedef struct packed {
        logic cal_out_sleep_route_enable;
        logic cal_en;
        rcc_freq_sel_t cal_freq_select;
        logic [3:0] route_sel;
    } rcc_cal_cfg_t;

    typedef struct packed {
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
    } rcc_cal_date_t;
endpackage

// File: verification/rcc_top_properties.sv
// port-level checker for the rtc calendar and calibration output block
`timescale 1ns/1ps
`default_nettype none
module rcc_top_checker (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    // status, calendar and pins
    input wire logic deep_sleep_power_mode_in,
    input wire logic day_tick_in,
    input wire logic fast_timekeeping_out,
    input wire logic year_tick_out,
    input wire logic [3:0] cal_route_out,
    input wire logic [3:0] cal_route_oe_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    logic [7:0] cfg_q;
    logic ctl_q;
    logic slp_q;
    logic [2:0] cfg_age_q;
    logic [2:0] slp_age_q;
    logic [1:0] tog_q;
    logic [15:0] run_q;
    logic slp;
    logic ok;
    logic [15:0] half;
    logic cfg_wr;
    assign cfg_wr = wr_in && (addr_in == rcc_pkg::REG_CAL_CFG);
    assign slp = deep_sleep_power_mode_in | ctl_q;
    // pin checks wait out the sync and register latency after any change
    assign ok = (cfg_age_q == 3'h7) && (slp_age_q == 3'h7);
    assign half = (cfg_q[5:4] == 2'h0) ? 16'h3FFF : (cfg_q[5:4] == 2'h3) ? 16'h0000 : 16'h001F;
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cfg_q <= 8'h00;
            ctl_q <= 1'b0;
            slp_q <= 1'b0;
            cfg_age_q <= 3'h0;
            slp_age_q <= 3'h0;
        end
        else
        begin
            if (cfg_wr)
                cfg_q <= wdata_in;
            if (wr_in && addr_in == rcc_pkg::REG_CTRL)
                ctl_q <= wdata_in[0];
            slp_q <= slp;
            cfg_age_q <= cfg_wr ? 3'h0 : (cfg_age_q == 3'h7) ? 3'h7 : cfg_age_q + 3'h1;
            slp_age_q <= (slp != slp_q) ? 3'h0 : (slp_age_q == 3'h7) ? 3'h7 : slp_age_q + 3'h1;
        end
    end
    // the first toggles after a change may be a restart, so count two first
    always_ff @(posedge clk_in)
    begin
        if (rst_in || cfg_wr || slp != slp_q)
            tog_q <= 2'h0;
        else if ($changed(cal_route_out[0]) && tog_q != 2'h3)
            tog_q <= tog_q + 2'h1;
        if (rst_in || $changed(cal_route_out[0]))
            run_q <= 16'h0000;
        else if (run_q != 16'hFFFF)
            run_q <= run_q + 16'h0001;
    end
    a_read_cfg: assert property (rd_in && addr_in == rcc_pkg::REG_CAL_CFG |=>
        rdata_out == $past(cfg_q)) else $error("config readback wrong");
    a_read_idle: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data outside its cycle");
    a_route_enable: assert property (ok && !slp |->
        cal_route_oe_out == (cfg_q[6] ? cfg_q[3:0] : 4'h0)) else $error("route enables wrong");
    a_sleep_route: assert property (ok && slp |->
        cal_route_oe_out == {3'h0, cfg_q[7] & cfg_q[6]}) else $error("deep sleep routes wrong");
    a_pins_quiet: assert property (ok && !cfg_q[6] |-> cal_route_out == 4'h0)
        else $error("pulse while disabled");
    a_wave_common: assert property (ok |-> ((cal_route_out & cal_route_oe_out) == 4'h0) ||
        ((cal_route_out & cal_route_oe_out) == cal_route_oe_out)) else $error("routes differ");
    a_fast_mode: assert property (ok |->
        fast_timekeeping_out == (cfg_q[6] & cfg_q[5] & ~slp)) else $error("speed-up wrong");
    a_wave_half: assert property (ok && !slp && cfg_q[6] && cfg_q[0] && tog_q >= 2'h2 &&
        $changed(cal_route_out[0]) |-> run_q == half) else $error("half period wrong");
    a_year_tick: assert property (year_tick_out |-> $past(day_tick_in, 2))
        else $error("year carry without day tick");
endmodule // rcc_top_checker
`default_nettype wire

// File: verification/test_rcc_top.sv
// self-checking testbench for the rtc calendar and calibration output block
`timescale 1ns/1ps
`default_nettype none
module test_rcc_top;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic deep_sleep_power_mode_in = 1'b0;
    logic day_tick_in = 1'b0;
    logic [7:0] rdata_out;
    logic fast_timekeeping_out;
    logic year_tick_out;
    logic [3:0] cal_route_out;
    logic [3:0] cal_route_oe_out;
    logic [7:0] years [6] = '{8'h00, 8'h04, 8'h60, 8'h61, 8'h64, 8'h30};
    int errors = 0;
    int tests_run = 0;
    always #25 clk_in = ~clk_in;
    rcc_top DUT (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .deep_sleep_power_mode_in(deep_sleep_power_mode_in), .day_tick_in(day_tick_in),
        .fast_timekeeping_out(fast_timekeeping_out), .year_tick_out(year_tick_out),
        .cal_route_out(cal_route_out), .cal_route_oe_out(cal_route_oe_out));
    task automatic tally_and_finish();
        if (errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, exp);
    endtask
    // the year carry is a one-cycle pulse, so watch a short window for it
    task automatic tick(output logic yt);
        @(posedge clk_in);
        day_tick_in <= 1'b1;
        @(posedge clk_in);
        day_tick_in <= 1'b0;
        yt = 1'b0;
        repeat (3)
        begin
            @(posedge clk_in);
            #1;
            yt = yt | year_tick_out;
        end
    endtask
    function automatic logic [7:0] mlen(input logic [7:0] m, input logic [7:0] y);
        if (m == 8'h02)
            return (y >= 8'h04 && y <= 8'h60 && y[1:0] == 2'h0) ? 8'h1D : 8'h1C;
        return (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h0B) ? 8'h1E : 8'h1F;
    endfunction
    // one day before the end, so an early wrap shows as well as a late one
    task automatic cal_case(input logic [7:0] m, input logic [7:0] y);
        logic [7:0] last;
        logic yt;
        last = mlen(m, y);
        wr(rcc_pkg::REG_YEAR, y);
        wr(rcc_pkg::REG_MONTH, m);
        wr(rcc_pkg::REG_DATE, last - 8'h01);
        tick(yt);
        rd(rcc_pkg::REG_DATE, last);
        tick(yt);
        rd(rcc_pkg::REG_DATE, 8'h01);
        rd(rcc_pkg::REG_MONTH, (m == 8'h0C) ? 8'h01 : m + 8'h01);
        rd(rcc_pkg::REG_YEAR, (m == 8'h0C) ? y + 8'h01 : y);
        chk({7'h00, yt}, {7'h00, m == 8'h0C});
    endtask
    // the pins must show the pulse high at least once on every driven route
    task automatic cal(input logic [7:0] c, input logic s, input logic [3:0] eoe, input logic ef);
        logic [3:0] seen;
        seen = 4'h0;
        @(posedge clk_in);
        deep_sleep_power_mode_in <= s;
        wr(rcc_pkg::REG_CAL_CFG, c);
        rd(rcc_pkg::REG_CAL_CFG, c);
        repeat (100)
        begin
            @(posedge clk_in);
            #1;
            seen = seen | cal_route_out;
        end
        chk({4'h0, cal_route_oe_out}, {4'h0, eoe});
        chk({7'h00, fast_timekeeping_out}, {7'h00, ef});
        chk({4'h0, seen}, {4'h0, eoe});
    endtask
    initial
    begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(rcc_pkg::REG_CAL_CFG, 8'h00);
        rd(rcc_pkg::REG_DATE, 8'h01);
        rd(rcc_pkg::REG_MONTH, 8'h01);
        rd(rcc_pkg::REG_YEAR, 8'h00);
        wr(8'h20, 8'h5A);
        rd(8'h20, 8'h00);
        for (int m = 1; m <= 12; m++)
            cal_case(8'(m), 8'h05);
        foreach (years[i])
            cal_case(8'h02, years[i]);
        for (int f = 0; f < 4; f++)
            cal({2'b01, 2'(f), 4'hF}, 1'b0, 4'hF, f[1]);
        for (int i = 0; i < 4; i++)
            cal(8'h40 | (8'h01 << i), 1'b0, 4'h1 << i, 1'b0);
        cal(8'h0F, 1'b0, 4'h0, 1'b0);
        cal(8'hFF, 1'b1, 4'h1, 1'b0);
        cal(8'h7F, 1'b1, 4'h0, 1'b0);
        cal(8'h3F, 1'b1, 4'h0, 1'b0);
        rd(rcc_pkg::REG_STATUS, 8'h01);
        wr(rcc_pkg::REG_CTRL, 8'h01);
        cal(8'hCE, 1'b0, 4'h1, 1'b0);
        // a second reset in mid-run must clear config, control and the month counter again
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        #1;
        chk({4'h0, cal_route_oe_out}, 8'h00);
        rd(rcc_pkg::REG_CAL_CFG, 8'h00);
        rd(rcc_pkg::REG_CTRL, 8'h00);
        rd(rcc_pkg::REG_MONTH, 8'h01);
        wr(rcc_pkg::REG_CTRL, 8'h00);
        tally_and_finish();
    end
    initial
    begin
        repeat (20000) @(posedge clk_in);
        errors++;
        $display("MISMATCH %0t run did not finish", $time);
        tally_and_finish();
    end
endmodule // test_rcc_top
bind rcc_top rcc_top_checker u_chk (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .deep_sleep_power_mode_in(deep_sleep_power_mode_in), .day_tick_in(day_tick_in),
    .fast_timekeeping_out(fast_timekeeping_out), .year_tick_out(year_tick_out),
    .cal_route_out(cal_route_out), .cal_route_oe_out(cal_route_oe_out));
`default_nettype wire
